// [design/irq_seq_pkg.sv]
// Functional notes
// - Accepting any interrupt clears the global enable, so no further interrupt is taken.
// - The return-from-isr instruction sets the global enable; software may also set it.
// - When the vector is loaded, the flag of the source being served is cleared.
// - Writing one to a flag position clears that flag; writing zero leaves it alone.
// - A request whose own enable is low still sets its flag, which stays set until cleared.
// - Requests seen while global enable is low stay latched and are served later by priority.
// - A level external request has no flag and is pending only while its input is active.
// - Interrupt entry takes at least four cycles before the vector instruction runs.
// - During entry the nine-bit program counter is pushed onto the stack.
// - A multi-cycle instruction completes before interrupt entry starts.
// - A request that wakes the core from sleep adds four cycles to the entry latency.
// - A return takes four cycles, during which the nine-bit program counter is popped.
// - After a return, one instruction of the interrupted program runs before any service.
package irq_seq_pkg;

    localparam int PC_WIDTH = 9;
    localparam int STACK_DEPTH = 3;
    localparam int NUM_SOURCES = 5;
    localparam int LEVEL_SRC = 0;
    localparam int CNT_WIDTH = 4;

    localparam logic [CNT_WIDTH-1:0] ENTRY_CYCLES = 4'h4;
    localparam logic [CNT_WIDTH-1:0] WAKE_EXTRA_CYCLES = 4'h4;
    localparam logic [CNT_WIDTH-1:0] RETURN_CYCLES = 4'h4;

    localparam logic [PC_WIDTH-1:0] VECTOR_BASE = 9'h001;
    localparam logic [PC_WIDTH-1:0] PC_RESET = 9'h000;
    localparam logic GIE_RESET = 1'b0;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ENTRY = 4'h2,
        ST_RETURN = 4'h4,
        ST_SETTLE = 4'h8
    } seq_state_type;

endpackage

// [design/pc_stack.sv]
`timescale 1ns/1ns
module pc_stack
    import irq_seq_pkg::*;
#(
    parameter int WIDTH = PC_WIDTH,
    parameter int DEPTH = STACK_DEPTH
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // stack operations
    input wire logic push,
    input wire logic pop,
    input wire logic [WIDTH-1:0] push_data,
    output logic [WIDTH-1:0] top_data
);

    localparam int IDXW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [IDXW-1:0] ptr_q;

    function automatic logic [IDXW-1:0] step(input logic [IDXW-1:0] p, input logic up);
        logic [IDXW-1:0] r;
        r = p;
        if (up) begin
            r = (p == IDXW'(DEPTH - 1)) ? '0 : IDXW'(p + 1'b1);
        end else begin
            r = (p == '0) ? IDXW'(DEPTH - 1) : IDXW'(p - 1'b1);
        end
        return r;
    endfunction

    // circular: an overflow silently overwrites the oldest entry
    wire logic [IDXW-1:0] top_idx = step(ptr_q, 1'b0);
    assign top_data = mem_q[top_idx];

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            ptr_q <= '0;
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= WIDTH'(PC_RESET);
            end
        end else if (push) begin
            mem_q[ptr_q] <= push_data;
            ptr_q <= step(ptr_q, 1'b1);
        end else if (pop) begin
            ptr_q <= top_idx;
        end
    end

endmodule // pc_stack

// [design/cpu_interrupt_sequencer.sv]
`timescale 1ns/1ns
module cpu_interrupt_sequencer
    import irq_seq_pkg::*;
#(
    parameter int NSRC = NUM_SOURCES
) (
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // peripheral requests
    input wire logic [NSRC-1:0] src_event,
    input wire logic [NSRC-1:0] src_enable,
    input wire logic level_mode,
    input wire logic level_req,
    // software control
    input wire logic flag_wr,
    input wire logic [NSRC-1:0] flag_wdata,
    input wire logic gie_set,
    input wire logic gie_clr,
    // core pipeline
    input wire logic instr_boundary,
    input wire logic sleeping,
    input wire logic return_from_isr_instr,
    input wire logic [PC_WIDTH-1:0] resume_pc,
    // status
    output logic gie_q,
    output logic [NSRC-1:0] flags_q,
    // pipeline control
    output logic core_hold_q,
    output logic vector_load_q,
    output logic [PC_WIDTH-1:0] vector_addr_q,
    output logic pc_load_q,
    output logic [PC_WIDTH-1:0] pc_out_q
);

    localparam int IDXW = (NSRC > 1) ? $clog2(NSRC) : 1;

    seq_state_type state_q;
    seq_state_type state_d;
    logic [CNT_WIDTH-1:0] cnt_q;
    logic [CNT_WIDTH-1:0] cnt_d;
    logic [IDXW-1:0] sel_q;
    logic [NSRC-1:0] flags_d;
    logic gie_d;
    logic [PC_WIDTH-1:0] stack_top;

    // lowest index wins, which is the lowest vector address
    function automatic logic [IDXW-1:0] first_set(input logic [NSRC-1:0] v);
        logic [IDXW-1:0] r;
        r = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IDXW'(i);
            end
        end
        return r;
    endfunction

    // level source: pending only while the pin condition holds, never latched
    wire logic level_live = level_mode & level_req;
    wire logic [NSRC-1:0] level_vec = {{(NSRC-1){1'b0}}, level_live};
    wire logic [NSRC-1:0] level_clr = {{(NSRC-1){1'b0}}, level_mode};
    wire logic [NSRC-1:0] pending = (flags_q | level_vec) & src_enable;

    wire logic st_idle = (state_q == ST_IDLE);
    wire logic st_entry = (state_q == ST_ENTRY);
    wire logic st_return = (state_q == ST_RETURN);
    wire logic st_settle = (state_q == ST_SETTLE);

    // settle releases on the boundary that ends the first resumed instruction;
    // the pop load cycle is a fetch, so a boundary flagged there does not count
    wire logic settle_go = st_settle & instr_boundary & ~pc_load_q;
    wire logic take_window = st_idle | settle_go;
    wire logic ret_take = take_window & return_from_isr_instr;
    // entry only between instructions, or from sleep where none runs
    wire logic entry_take = take_window & gie_q & (|pending)
                            & (instr_boundary | sleeping) & ~return_from_isr_instr;
    wire logic entry_done = st_entry & (cnt_q == '0);
    wire logic ret_done = st_return & (cnt_q == '0);

    wire logic [CNT_WIDTH-1:0] entry_len = sleeping ? (ENTRY_CYCLES + WAKE_EXTRA_CYCLES)
                                                    : ENTRY_CYCLES;
    wire logic [NSRC-1:0] sel_mask = NSRC'(1) << sel_q;
    wire logic [NSRC-1:0] hw_clr = entry_done ? sel_mask : '0;
    wire logic [NSRC-1:0] sw_clr = flag_wr ? flag_wdata : '0;

    // new events win over either clear in the same cycle
    assign flags_d = ((flags_q & ~sw_clr & ~hw_clr) | src_event) & ~level_clr;

    always_comb begin
        if (entry_take) begin
            gie_d = 1'b0;
        end else if (gie_set | ret_done) begin
            gie_d = 1'b1;
        end else if (gie_clr) begin
            gie_d = 1'b0;
        end else begin
            gie_d = gie_q;
        end
    end

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_IDLE, ST_SETTLE: begin
                if (ret_take) begin
                    state_d = ST_RETURN;
                    cnt_d = RETURN_CYCLES - 4'h1;
                end else if (entry_take) begin
                    state_d = ST_ENTRY;
                    cnt_d = entry_len - 4'h1;
                end else if (settle_go) begin
                    state_d = ST_IDLE;
                end
            end
            ST_ENTRY: begin
                if (cnt_q == '0) begin
                    state_d = ST_IDLE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            ST_RETURN: begin
                if (cnt_q == '0) begin
                    state_d = ST_SETTLE;
                end else begin
                    cnt_d = cnt_q - 4'h1;
                end
            end
            default: begin
                state_d = ST_IDLE;
                cnt_d = '0;
            end
        endcase
    end

    wire logic hold_d = (state_d == ST_ENTRY) | (state_d == ST_RETURN);
    wire logic [PC_WIDTH-1:0] vec_d = VECTOR_BASE + PC_WIDTH'(sel_q);

    pc_stack #(
        .WIDTH(PC_WIDTH),
        .DEPTH(STACK_DEPTH)
    ) u_stack (
        .mclk(mclk),
        .nrst(nrst),
        .push(entry_take),
        .pop(ret_done),
        .push_data(resume_pc),
        .top_data(stack_top)
    );

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            sel_q <= '0;
            gie_q <= GIE_RESET;
            flags_q <= '0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            if (entry_take) begin
                sel_q <= first_set(pending);
            end
            gie_q <= gie_d;
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            core_hold_q <= 1'b0;
            vector_load_q <= 1'b0;
            vector_addr_q <= VECTOR_BASE;
            pc_load_q <= 1'b0;
            pc_out_q <= PC_RESET;
        end else begin
            core_hold_q <= hold_d;
            vector_load_q <= entry_done;
            pc_load_q <= ret_done;
            if (entry_done) begin
                vector_addr_q <= vec_d;
            end
            if (ret_done) begin
                pc_out_q <= stack_top;
            end
        end
    end

    a_entry_gie_off: assert property (
        @(posedge mclk) disable iff (!nrst) entry_take |=> !gie_q)
        else $error("global enable still set after accepting an interrupt");

    a_return_gie_on: assert property (
        @(posedge mclk) disable iff (!nrst) ret_done |=> gie_q && pc_load_q)
        else $error("global enable not set on return");

    a_vector_flag_clear: assert property (
        @(posedge mclk) disable iff (!nrst)
        entry_done && !src_event[sel_q] |=> vector_load_q && !flags_q[$past(sel_q)])
        else $error("served flag not cleared at vector load");

    a_write_one_clear: assert property (
        @(posedge mclk) disable iff (!nrst)
        flag_wr |=> (flags_q & $past(flag_wdata & ~src_event)) == '0)
        else $error("write of one did not clear flag");

    a_write_zero_keep: assert property (
        @(posedge mclk) disable iff (!nrst)
        flag_wr && !entry_done |=>
        (flags_q & $past(flags_q & ~flag_wdata & ~level_clr))
            == $past(flags_q & ~flag_wdata & ~level_clr))
        else $error("write of zero changed a flag");

    a_flag_sticky: assert property (
        @(posedge mclk) disable iff (!nrst)
        src_event != '0 |=>
        (flags_q & $past(src_event & ~level_clr)) == $past(src_event & ~level_clr))
        else $error("request lost its flag");

    a_gie_blocks: assert property (
        @(posedge mclk) disable iff (!nrst)
        core_hold_q && !$past(core_hold_q) && !$past(return_from_isr_instr) |-> $past(gie_q))
        else $error("interrupt taken with global enable low");

    a_no_level_flag: assert property (
        @(posedge mclk) disable iff (!nrst) level_mode |=> !flags_q[LEVEL_SRC])
        else $error("level source left a latched flag");

    a_entry_latency: assert property (
        @(posedge mclk) disable iff (!nrst)
        entry_take && !sleeping |=> core_hold_q && !vector_load_q [*4] ##1 vector_load_q)
        else $error("entry latency not four cycles");

    a_sleep_latency: assert property (
        @(posedge mclk) disable iff (!nrst)
        entry_take && sleeping |=> !vector_load_q [*8] ##1 vector_load_q)
        else $error("wake entry latency not eight cycles");

    a_boundary_only: assert property (
        @(posedge mclk) disable iff (!nrst)
        core_hold_q && !$past(core_hold_q) && !$past(return_from_isr_instr)
            |-> $past(instr_boundary) || $past(sleeping))
        else $error("entry started inside an instruction");

    a_return_pop: assert property (
        @(posedge mclk) disable iff (!nrst)
        ret_take |=> !pc_load_q [*4] ##1 (pc_load_q && !core_hold_q))
        else $error("return not four cycles");

    a_one_instr: assert property (
        @(posedge mclk) disable iff (!nrst) pc_load_q |-> st_settle && !entry_take)
        else $error("interrupt served before one resumed instruction");

    a_prio_order: assert property (
        @(posedge mclk) disable iff (!nrst)
        entry_take |=> ($past(pending) & sel_mask) != '0
            && ($past(pending) & (sel_mask - NSRC'(1))) == '0)
        else $error("not the lowest pending source");

endmodule // cpu_interrupt_sequencer

// [tb/core_model.sv]
`timescale 1ns/1ns
module core_model
    import irq_seq_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // bench control
    input wire logic multi,
    input wire logic ret_req,
    input wire logic sleeping,
    // sequencer side
    input wire logic core_hold_q,
    input wire logic vector_load_q,
    input wire logic [PC_WIDTH-1:0] vector_addr_q,
    input wire logic pc_load_q,
    input wire logic [PC_WIDTH-1:0] pc_out_q,
    output logic instr_boundary,
    output logic return_from_isr_instr,
    output logic [PC_WIDTH-1:0] resume_pc,
    // fetch address
    output logic [PC_WIDTH-1:0] pc_q
);
    logic [1:0] step_q;
    logic run;

    // a load cycle is a fetch, so no instruction ends there
    assign run = !core_hold_q && !sleeping && !vector_load_q && !pc_load_q;
    // a long instruction ends only in its third cycle
    assign instr_boundary = run && (!multi || step_q == 2'h2);
    assign return_from_isr_instr = instr_boundary && ret_req;
    // asleep, pc_q already names the next instruction, nothing is half done
    assign resume_pc = sleeping ? pc_q : pc_q + 9'h001;

    // status register is never stacked here, service code owns it
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            pc_q <= PC_RESET;
            step_q <= 2'h0;
        end else if (vector_load_q) begin
            pc_q <= vector_addr_q;
        end else if (pc_load_q) begin
            pc_q <= pc_out_q;
        end else if (instr_boundary) begin
            pc_q <= resume_pc;
            step_q <= 2'h0;
        end else if (run) begin
            step_q <= step_q + 2'h1;
        end
    end
endmodule // core_model

// [tb/cpu_interrupt_sequencer_tb.sv]
`timescale 1ns/1ns
`define chk(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin miscompares++; \
    $display("[ERR] %s exp %0h got %0h", nm, exp, got); end end
module cpu_interrupt_sequencer_tb
    import irq_seq_pkg::*;
;
    typedef struct {logic [4:0] mask; int idx; logic slp; logic mul; int hold;} row_type;
    row_type rows [5] = '{'{5'h01, 0, 1'b0, 1'b0, 4}, '{5'h02, 1, 1'b0, 1'b0, 4},
        '{5'h04, 2, 1'b1, 1'b0, 8}, '{5'h08, 3, 1'b0, 1'b1, 4}, '{5'h10, 4, 1'b0, 1'b0, 4}};
    logic mclk, nrst, level_mode, level_req, flag_wr, gie_set, gie_clr, sleeping;
    logic instr_boundary, return_from_isr_instr, gie_q, core_hold_q, vector_load_q, pc_load_q;
    logic multi, ret_req;
    logic [4:0] src_event, src_enable, flag_wdata, flags_q;
    logic [PC_WIDTH-1:0] resume_pc, vector_addr_q, pc_out_q, pc_q, last_ret;
    int miscompares = 0;
    int n_tests = 0;
    int cyc = 0;

    cpu_interrupt_sequencer u_dut (.mclk(mclk), .nrst(nrst), .src_event(src_event),
        .src_enable(src_enable), .level_mode(level_mode), .level_req(level_req),
        .flag_wr(flag_wr), .flag_wdata(flag_wdata), .gie_set(gie_set), .gie_clr(gie_clr),
        .instr_boundary(instr_boundary), .sleeping(sleeping),
        .return_from_isr_instr(return_from_isr_instr), .resume_pc(resume_pc),
        .gie_q(gie_q), .flags_q(flags_q), .core_hold_q(core_hold_q),
        .vector_load_q(vector_load_q), .vector_addr_q(vector_addr_q),
        .pc_load_q(pc_load_q), .pc_out_q(pc_out_q));
    core_model u_core (.mclk(mclk), .nrst(nrst), .multi(multi), .ret_req(ret_req),
        .sleeping(sleeping), .core_hold_q(core_hold_q), .vector_load_q(vector_load_q),
        .vector_addr_q(vector_addr_q), .pc_load_q(pc_load_q), .pc_out_q(pc_out_q),
        .instr_boundary(instr_boundary), .return_from_isr_instr(return_from_isr_instr),
        .resume_pc(resume_pc), .pc_q(pc_q));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    task wrap_up();
        if (miscompares == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // generous: the whole sequence needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            miscompares++;
            wrap_up();
        end
    end

    task idle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task strobe(input logic [4:0] ev, input logic [4:0] wr, input logic set, input logic clr);
        @(posedge mclk);
        src_event <= ev;
        flag_wr <= |wr;
        flag_wdata <= wr;
        gie_set <= set;
        gie_clr <= clr;
        @(posedge mclk);
        src_event <= 5'h00;
        flag_wr <= 1'b0;
        gie_set <= 1'b0;
        gie_clr <= 1'b0;
        #1;
    endtask

    // one full service: entry, checks, return; chain means it follows a return directly
    task serve(input int idx, input int hold_exp, input logic chain);
        int hold;
        logic prev_bd;
        logic [PC_WIDTH-1:0] saved;
        hold = 0;
        prev_bd = instr_boundary;
        for (int i = 0; i < 60 && vector_load_q !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
            if (core_hold_q === 1'b1 && hold == 0) begin
                saved = pc_q;
                `chk("take_at_boundary", 1'b1, prev_bd | sleeping)
                if (chain)
                    `chk("one_instr_after_ret", last_ret + 9'h001, saved)
            end
            if (core_hold_q === 1'b1)
                hold++;
            prev_bd = instr_boundary;
        end
        `chk("entry_cycles", hold_exp, hold)
        `chk("vector", VECTOR_BASE + 9'(idx), vector_addr_q)
        `chk("gie_entry", 1'b0, gie_q)
        `chk("flag_clear", 1'b0, flags_q[idx])
        @(posedge mclk);
        sleeping <= 1'b0;
        level_req <= 1'b0;
        ret_req <= 1'b1;
        hold = 0;
        for (int i = 0; i < 60 && pc_load_q !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
            if (core_hold_q === 1'b1)
                hold++;
        end
        `chk("return_cycles", 4, hold)
        `chk("popped_pc", saved, pc_out_q)
        `chk("gie_return", 1'b1, gie_q)
        last_ret = pc_out_q;
        @(posedge mclk);
        ret_req <= 1'b0;
        #1;
    endtask

    initial begin
        nrst = 1'b0;
        {level_mode, level_req, flag_wr, gie_set, gie_clr, sleeping, multi, ret_req} = '0;
        src_event = 5'h00;
        flag_wdata = 5'h00;
        src_enable = 5'h1f;
        idle(4);
        `chk("gie_reset", GIE_RESET, gie_q)
        `chk("flags_reset", 5'h00, flags_q)
        `chk("vec_reset", VECTOR_BASE, vector_addr_q)
        @(posedge mclk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            strobe(5'h00, 5'h00, 1'b1, 1'b0);
            @(posedge mclk);
            sleeping <= rows[i].slp;
            multi <= rows[i].mul;
            strobe(rows[i].mask, 5'h00, 1'b0, 1'b0);
            serve(rows[i].idx, rows[i].hold, 1'b0);
        end
        @(posedge mclk);
        multi <= 1'b0;
        src_enable <= 5'h00;
        strobe(5'h1f, 5'h00, 1'b0, 1'b0);
        idle(8);
        `chk("flags_masked", 5'h1f, flags_q)
        `chk("no_entry_masked", 1'b0, core_hold_q)
        strobe(5'h00, 5'h05, 1'b0, 1'b0);
        `chk("flags_w1c", 5'h1a, flags_q)
        strobe(5'h00, 5'h00, 1'b0, 1'b1);
        @(posedge mclk);
        src_enable <= 5'h1f;
        idle(6);
        `chk("flags_held", 5'h1a, flags_q)
        `chk("no_entry_gie_off", 1'b0, core_hold_q)
        strobe(5'h00, 5'h00, 1'b1, 1'b0);
        serve(1, 4, 1'b0);
        serve(3, 4, 1'b1);
        serve(4, 4, 1'b1);
        @(posedge mclk);
        level_mode <= 1'b1;
        strobe(5'h01, 5'h00, 1'b0, 1'b0);
        idle(6);
        `chk("level_no_flag", 1'b0, flags_q[0])
        `chk("level_idle", 1'b0, core_hold_q)
        @(posedge mclk);
        level_req <= 1'b1;
        #1;
        serve(0, 4, 1'b0);
        idle(6);
        `chk("level_gone", 1'b0, core_hold_q)
        wrap_up();
    end
endmodule // cpu_interrupt_sequencer_tb
